// [ddc_nco_decimator.sv]
// Purpose: oscillator, complex mixer, decimating filter, gain and quarter-rate remix
// Assumes: clk_sys is the sampling clock; host reads results from the out ports
// Notes:   filter is a boxcar accumulate-and-dump with 25-bit accumulators and 20-bit output
//
// What this block does
// - complex mode shifts by oscillator frequency, low-passes around zero, decimates
// - complex mode offers software-enabled 6 dB gain
// - real mode applies no shift, filters real part only, decimates
// - real mode offers software-enabled 3 dB gain
// - quarter-rate remix turns complex output into real stream at twice rate
// - 32-bit oscillator rotates positive by default, negative when selected
// - frequency word is signed, spanning minus to plus half sampling rate
// - in complex mode each real sample is multiplied by complex oscillator output
// - new frequency word takes effect only after restart bit toggle, soft align toggle or align pin rising edge
// - software can invert mixer phase, swapping rotation direction
// - decimation factors 2, 4, 8, 16, 32 give rate sampling rate over factor
// - real mode bandwidth is half the complex bandwidth
// - align enable turns shared powerdown pin into align input
// - align input is sampled on rising clock edge
// - alignment comes from register bit or pin, needed only with filter
// - alignment resets decimation dividers, keeping I and Q on same sample
// - without alignment the decimation dividers run free
// - alignment resets oscillator phase and loads pending word like restart
// - filter arithmetic runs at 25 bits; truncation to 20 bits happens after averaging
// - real mode bypasses the mixer; software should zero the word
//
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module ddc_nco_decimator (
	// clock and reset
	input  wire logic                             clk_sys,
	input  wire logic                             rst,
	// register port
	input  wire logic [ddc_pkg::ADDR_W-1:0]       regAddr,
	input  wire logic [ddc_pkg::DATA_W-1:0]       regWrData,
	input  wire logic                             regWr,
	input  wire logic                             regRd,
	output logic      [ddc_pkg::DATA_W-1:0]       regRdData,
	// converter samples
	input  wire logic signed [ddc_pkg::SMP_W-1:0] smpIn,
	input  wire logic                             smpValid,
	// shared pin
	input  wire logic                             powerdown_or_align_pin,
	output logic                                  powerDown,
	// decimated stream
	output logic signed [ddc_pkg::ACC_W-1:0]      outI,
	output logic signed [ddc_pkg::ACC_W-1:0]      outQ,
	output logic                                  outValid,
	output logic                                  outReal
);
	typedef struct packed {
		logic [ddc_pkg::CTRL_W-1:0]         ctrl;
		logic [ddc_pkg::DEC_W-1:0]          decim;
		logic [ddc_pkg::FREQ_W-1:0]         freqPend;
		logic [ddc_pkg::FREQ_W-1:0]         freqAct;
		logic [ddc_pkg::FREQ_W-1:0]         phase;
		logic                               pinMeta;
		logic                               pinSync;
		logic                               pinPrev;
		logic                               restartPrev;
		logic                               softPrev;
		logic                               alignedSeen;
		logic signed [ddc_pkg::SMP_W-1:0]   smpD;
		logic                               smpDValid;
		logic signed [ddc_pkg::ACC_W-1:0]   mixI;
		logic signed [ddc_pkg::ACC_W-1:0]   mixQ;
		logic                               mixValid;
		logic [ddc_pkg::CNT_W-1:0]          decCnt;
		logic signed [ddc_pkg::SUM_W-1:0]   accI;
		logic signed [ddc_pkg::SUM_W-1:0]   accQ;
		logic [1:0]                         remixPh;
		logic signed [ddc_pkg::ACC_W-1:0]   remixHold;
		logic                               remixPend;
		logic signed [ddc_pkg::ACC_W-1:0]   outI;
		logic signed [ddc_pkg::ACC_W-1:0]   outQ;
		logic                               outValid;
		logic                               outReal;
		logic [ddc_pkg::DATA_W-1:0]         rdData;
		logic                               powerDown;
	} ddc_state_s;

	ddc_state_s st_r;
	ddc_state_s st_nxt;

	logic signed [ddc_pkg::LUT_W-1:0] romSin;
	logic signed [ddc_pkg::LUT_W-1:0] romCos;

	ddc_sine_rom u_rom (
		.clk_sys (clk_sys),
		.rst     (rst),
		.phase   (st_r.phase[ddc_pkg::FREQ_W-1 -: ddc_pkg::LUTA_W]),
		.sinOut  (romSin),
		.cosOut  (romCos)
	);

	// saturate a 22-bit value into the 20-bit path
	function automatic logic signed [ddc_pkg::ACC_W-1:0] sat20(input logic signed [21:0] v);
		logic signed [ddc_pkg::ACC_W-1:0] r;
		r = v[19:0];
		if (v > 22'sh07FFFF) begin
			r = 20'sh7FFFF;
		end else if (v < -22'sh080000) begin
			r = 20'sh80000;
		end
		return r;
	endfunction : sat20

	// compensation gain: doubling in complex mode, about root two in real mode
	function automatic logic signed [ddc_pkg::ACC_W-1:0] gain(input logic signed [ddc_pkg::ACC_W-1:0] v,
		input logic en, input logic cplx);
		logic signed [21:0] w;
		logic signed [21:0] r;
		w = {{2{v[19]}}, v};
		r = w;
		if (en && cplx) begin
			r = w <<< 1;
		end else if (en) begin
			r = w + (w >>> 2) + (w >>> 3) + (w >>> 5);
		end
		return sat20(r);
	endfunction : gain

	logic                               restartEv;
	logic                               alignEv;
	logic                               loadEv;
	logic                               cplxMode;
	logic [ddc_pkg::CNT_W-1:0]          lastCnt;
	logic signed [ddc_pkg::SMP_W+ddc_pkg::LUT_W-1:0] prodI;
	logic signed [ddc_pkg::SMP_W+ddc_pkg::LUT_W-1:0] prodQ;
	logic signed [ddc_pkg::SUM_W-1:0]   sumI;
	logic signed [ddc_pkg::SUM_W-1:0]   sumQ;
	logic signed [ddc_pkg::SUM_W-1:0]   avgI;
	logic signed [ddc_pkg::SUM_W-1:0]   avgQ;
	logic signed [ddc_pkg::ACC_W-1:0]   gI;
	logic signed [ddc_pkg::ACC_W-1:0]   gQ;
	logic signed [ddc_pkg::ACC_W-1:0]   smpWide;

	always_comb begin
		st_nxt = st_r;
		cplxMode = st_r.ctrl[ddc_pkg::CTRL_COMPLEX];
		lastCnt = (5'h02 << st_r.decim) - 5'h01;
		// pin synchroniser and edge detect
		st_nxt.pinMeta = powerdown_or_align_pin;
		st_nxt.pinSync = st_r.pinMeta;
		st_nxt.pinPrev = st_r.pinSync;
		st_nxt.powerDown = st_r.ctrl[ddc_pkg::CTRL_ALIGN_EN] ? 1'b0 : st_r.pinSync;
		// toggle of either control bit is an event
		restartEv = st_r.ctrl[ddc_pkg::CTRL_RESTART] != st_r.restartPrev;
		alignEv = (st_r.ctrl[ddc_pkg::CTRL_SOFT_ALN] != st_r.softPrev)
			|| (st_r.ctrl[ddc_pkg::CTRL_ALIGN_EN] && st_r.pinSync && !st_r.pinPrev);
		loadEv = restartEv || alignEv;
		st_nxt.restartPrev = st_r.ctrl[ddc_pkg::CTRL_RESTART];
		st_nxt.softPrev = st_r.ctrl[ddc_pkg::CTRL_SOFT_ALN];
		if (alignEv) begin
			st_nxt.alignedSeen = 1'b1;
		end
		// register port
		st_nxt.rdData = '0;
		if (regWr) begin
			if (regAddr == ddc_pkg::OFS_CTRL) begin
				st_nxt.ctrl = regWrData[ddc_pkg::CTRL_W-1:0];
			end else if (regAddr == ddc_pkg::OFS_DECIM) begin
				st_nxt.decim = (regWrData[2:0] > ddc_pkg::DECIM_MAX) ? ddc_pkg::DECIM_MAX : regWrData[2:0];
			end else if (regAddr == ddc_pkg::OFS_FREQ) begin
				st_nxt.freqPend = regWrData;
			end
		end
		if (regRd) begin
			if (regAddr == ddc_pkg::OFS_CTRL) begin
				st_nxt.rdData = {24'h000000, st_r.ctrl};
			end else if (regAddr == ddc_pkg::OFS_DECIM) begin
				st_nxt.rdData = {29'h00000000, st_r.decim};
			end else if (regAddr == ddc_pkg::OFS_FREQ) begin
				st_nxt.rdData = st_r.freqPend;
			end else if (regAddr == ddc_pkg::OFS_STATUS) begin
				st_nxt.rdData = '0;
				st_nxt.rdData[ddc_pkg::STAT_ALIGNED] = st_r.alignedSeen;
				st_nxt.rdData[ddc_pkg::STAT_PIN] = st_r.pinSync;
				st_nxt.rdData[ddc_pkg::STAT_CNT_LO +: ddc_pkg::CNT_W] = st_r.decCnt;
			end else if (regAddr == ddc_pkg::OFS_ACTIVE) begin
				st_nxt.rdData = st_r.freqAct;
			end
		end
		// oscillator: wraps naturally at 32 bits, word is two's complement
		if (loadEv) begin
			st_nxt.phase = '0;
			st_nxt.freqAct = st_r.freqPend;
		end else if (smpValid) begin
			st_nxt.phase = st_r.phase + st_r.freqAct;
		end
		// delay samples one cycle to meet the table output
		st_nxt.smpD = smpIn;
		st_nxt.smpDValid = smpValid;
		// mixer
		prodI = st_r.smpD * romCos;
		prodQ = st_r.smpD * romSin;
		smpWide = {{(ddc_pkg::ACC_W-ddc_pkg::SMP_W-ddc_pkg::SMP_SHIFT){st_r.smpD[ddc_pkg::SMP_W-1]}},
			st_r.smpD, 6'h00};
		st_nxt.mixValid = st_r.smpDValid;
		if (cplxMode) begin
			st_nxt.mixI = prodI[24:5];
			st_nxt.mixQ = st_r.ctrl[ddc_pkg::CTRL_INVERT] ? -prodQ[24:5] : prodQ[24:5];
		end else begin
			st_nxt.mixI = smpWide;
			st_nxt.mixQ = '0;
		end
		// accumulate and dump
		sumI = st_r.accI + {{(ddc_pkg::SUM_W-ddc_pkg::ACC_W){st_r.mixI[19]}}, st_r.mixI};
		sumQ = st_r.accQ + {{(ddc_pkg::SUM_W-ddc_pkg::ACC_W){st_r.mixQ[19]}}, st_r.mixQ};
		avgI = sumI >>> ({2'b00, st_r.decim} + 5'h01);
		avgQ = sumQ >>> ({2'b00, st_r.decim} + 5'h01);
		gI = gain(avgI[19:0], st_r.ctrl[ddc_pkg::CTRL_GAIN], cplxMode);
		gQ = gain(avgQ[19:0], st_r.ctrl[ddc_pkg::CTRL_GAIN], cplxMode);
		st_nxt.outValid = 1'b0;
		// remix only runs behind the filter, so a bypassed complex stream stays complex
		st_nxt.outReal = !cplxMode || (st_r.ctrl[ddc_pkg::CTRL_REMIX] && st_r.ctrl[ddc_pkg::CTRL_FILT_EN]);
		if (!st_r.ctrl[ddc_pkg::CTRL_FILT_EN]) begin
			st_nxt.remixPend = 1'b0;
			if (st_r.mixValid) begin
				st_nxt.outI = st_r.mixI;
				st_nxt.outQ = st_r.mixQ;
				st_nxt.outValid = 1'b1;
			end
		end else begin
			// second remix sample of a pair goes out the cycle after the first
			if (st_r.remixPend) begin
				st_nxt.remixPend = 1'b0;
				st_nxt.outI = st_r.remixHold;
				st_nxt.outQ = '0;
				st_nxt.outValid = 1'b1;
			end
			if (st_r.mixValid) begin
				if (st_r.decCnt >= lastCnt) begin
					st_nxt.decCnt = '0;
					st_nxt.accI = '0;
					st_nxt.accQ = '0;
					if (cplxMode && st_r.ctrl[ddc_pkg::CTRL_REMIX]) begin
						// rotate by a quarter turn per real output sample
						st_nxt.outI = st_r.remixPh[1] ? -gI : gI;
						st_nxt.remixHold = st_r.remixPh[1] ? gQ : -gQ;
						st_nxt.remixPh = st_r.remixPh + 2'h2;
						st_nxt.remixPend = 1'b1;
						st_nxt.outQ = '0;
					end else begin
						st_nxt.outI = gI;
						st_nxt.outQ = cplxMode ? gQ : '0;
					end
					st_nxt.outValid = 1'b1;
				end else begin
					st_nxt.decCnt = st_r.decCnt + 5'h01;
					st_nxt.accI = sumI;
					st_nxt.accQ = sumQ;
				end
			end
		end
		if (alignEv) begin
			// both paths restart together, so I and Q stay on one sample
			st_nxt.decCnt = '0;
			st_nxt.accI = '0;
			st_nxt.accQ = '0;
			st_nxt.remixPh = '0;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st_r <= '0;
			st_r.ctrl <= ddc_pkg::CTRL_RST;
			st_r.decim <= ddc_pkg::DECIM_RST;
			st_r.freqPend <= ddc_pkg::FREQ_RST;
			st_r.freqAct <= ddc_pkg::FREQ_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign regRdData = st_r.rdData;
	assign powerDown = st_r.powerDown;
	assign outI      = st_r.outI;
	assign outQ      = st_r.outQ;
	assign outValid  = st_r.outValid;
	assign outReal   = st_r.outReal;
endmodule : ddc_nco_decimator
`default_nettype wire

// [ddc_pkg.sv]
// Purpose: shared constants of the down-conversion path
// Assumes: one input sample per clk_sys cycle at most, flagged by a valid
// Notes:   register offsets are byte addresses of 32-bit words
package ddc_pkg;
	// widths
	localparam int SMP_W   = 14;
	localparam int ACC_W   = 20;
	localparam int SUM_W   = 25;
	localparam int FREQ_W  = 32;
	localparam int LUT_W   = 12;
	localparam int LUTA_W  = 6;
	localparam int ADDR_W  = 8;
	localparam int DATA_W  = 32;
	localparam int CNT_W   = 5;
	localparam int DEC_W   = 3;
	// register offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_DECIM  = 8'h04;
	localparam logic [7:0] OFS_FREQ   = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam logic [7:0] OFS_ACTIVE = 8'h10;
	// control field positions
	localparam int CTRL_FILT_EN  = 0;
	localparam int CTRL_COMPLEX  = 1;
	localparam int CTRL_GAIN     = 2;
	localparam int CTRL_REMIX    = 3;
	localparam int CTRL_INVERT   = 4;
	localparam int CTRL_ALIGN_EN = 5;
	localparam int CTRL_RESTART  = 6;
	localparam int CTRL_SOFT_ALN = 7;
	localparam int CTRL_W        = 8;
	// status field positions
	localparam int STAT_ALIGNED  = 0;
	localparam int STAT_PIN      = 1;
	localparam int STAT_CNT_LO   = 8;
	// reset values and the largest decimation code
	localparam logic [7:0]  CTRL_RST  = 8'h00;
	localparam logic [2:0]  DECIM_RST = 3'h0;
	localparam logic [2:0]  DECIM_MAX = 3'h4;
	localparam logic [31:0] FREQ_RST  = 32'h0000_0000;
	// scaling of a raw sample into the 20-bit path
	localparam int SMP_SHIFT = 6;
endpackage : ddc_pkg

// [ddc_sine_rom.sv]
// Purpose: quarter-wave sine and cosine table, registered outputs
// Assumes: 64 phase steps per turn
// Notes:   one cycle from phase to data
`timescale 1ns/1ps
`default_nettype none
module ddc_sine_rom (
	// clock and reset
	input  wire logic                              clk_sys,
	input  wire logic                              rst,
	// phase in
	input  wire logic [ddc_pkg::LUTA_W-1:0]        phase,
	// table out
	output logic signed [ddc_pkg::LUT_W-1:0]       sinOut,
	output logic signed [ddc_pkg::LUT_W-1:0]       cosOut
);
	typedef struct packed {
		logic signed [ddc_pkg::LUT_W-1:0] sinV;
		logic signed [ddc_pkg::LUT_W-1:0] cosV;
	} ddc_rom_s;

	ddc_rom_s st_r;
	ddc_rom_s st_nxt;

	function automatic logic signed [ddc_pkg::LUT_W-1:0] quarter(input logic [4:0] i);
		logic signed [ddc_pkg::LUT_W-1:0] v;
		v = 12'sh000;
		case (i)
			5'h00: v = 12'sh000;
			5'h01: v = 12'sh0C9;
			5'h02: v = 12'sh18F;
			5'h03: v = 12'sh252;
			5'h04: v = 12'sh30F;
			5'h05: v = 12'sh3C5;
			5'h06: v = 12'sh471;
			5'h07: v = 12'sh513;
			5'h08: v = 12'sh5A7;
			5'h09: v = 12'sh62E;
			5'h0A: v = 12'sh6A6;
			5'h0B: v = 12'sh70D;
			5'h0C: v = 12'sh763;
			5'h0D: v = 12'sh7A7;
			5'h0E: v = 12'sh7D8;
			5'h0F: v = 12'sh7F5;
			default: v = 12'sh7FF;
		endcase
		return v;
	endfunction : quarter

	function automatic logic signed [ddc_pkg::LUT_W-1:0] sine(input logic [ddc_pkg::LUTA_W-1:0] p);
		logic [4:0]                       idx;
		logic signed [ddc_pkg::LUT_W-1:0] m;
		idx = p[4] ? (5'h10 - {1'b0, p[3:0]}) : {1'b0, p[3:0]};
		m = quarter(idx);
		return p[5] ? -m : m;
	endfunction : sine

	always_comb begin
		st_nxt      = st_r;
		st_nxt.sinV = sine(phase);
		st_nxt.cosV = sine(phase + 6'h10);
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign sinOut = st_r.sinV;
	assign cosOut = st_r.cosV;
endmodule : ddc_sine_rom
`default_nettype wire

// [ddc_nco_decimator_checker.sv]
// Purpose: port-level checks of the down-conversion block
// Assumes: bound to every ddc_nco_decimator instance
// Notes:   sees only the top module's ports
`timescale 1ns/1ps
`default_nettype none
module ddc_nco_decimator_checker (
	// clock and reset
	input wire logic                             clk_sys,
	input wire logic                             rst,
	// register port
	input wire logic [ddc_pkg::ADDR_W-1:0]       regAddr,
	input wire logic [ddc_pkg::DATA_W-1:0]       regWrData,
	input wire logic                             regWr,
	input wire logic                             regRd,
	input wire logic [ddc_pkg::DATA_W-1:0]       regRdData,
	// samples and shared pin
	input wire logic signed [ddc_pkg::SMP_W-1:0] smpIn,
	input wire logic                             smpValid,
	input wire logic                             powerdown_or_align_pin,
	input wire logic                             powerDown,
	// decimated stream
	input wire logic signed [ddc_pkg::ACC_W-1:0] outI,
	input wire logic signed [ddc_pkg::ACC_W-1:0] outQ,
	input wire logic                             outValid,
	input wire logic                             outReal
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence s_idle;
		!smpValid [*5];
	endsequence
	sequence s_odd_read;
		regRd && !(regAddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10});
	endsequence
	property p_rd_zero;     !regRd |=> regRdData == 32'h0; endproperty
	property p_rd_unmapped; s_odd_read |=> regRdData == 32'h0; endproperty
	property p_rd_decim;    regRd && regAddr == ddc_pkg::OFS_DECIM |=> regRdData <= 32'h4; endproperty
	property p_pd;          powerDown |-> $past(powerdown_or_align_pin, 3); endproperty
	property p_cause;       outValid |-> $past(smpValid, 3) || $past(outValid); endproperty
	property p_q_real;      outValid && outReal |-> outQ == 20'h0; endproperty
	property p_hold;        !outValid |-> $stable(outI) && $stable(outQ); endproperty
	property p_quiet;       s_idle |-> ##3 !outValid; endproperty
	a_rd_zero:     assert property (p_rd_zero) else $error("read data outside read slot");
	a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
	a_rd_decim:    assert property (p_rd_decim) else $error("decimation code out of range");
	a_pd:          assert property (p_pd) else $error("powerdown without pin");
	a_cause:       assert property (p_cause) else $error("output without sample");
	a_q_real:      assert property (p_q_real) else $error("real stream with Q");
	a_hold:        assert property (p_hold) else $error("output moved without valid");
	a_quiet:       assert property (p_quiet) else $error("output after idle input");
endmodule : ddc_nco_decimator_checker
bind ddc_nco_decimator ddc_nco_decimator_checker u_chk (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr),
	.regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .smpIn(smpIn),
	.smpValid(smpValid), .powerdown_or_align_pin(powerdown_or_align_pin), .powerDown(powerDown),
	.outI(outI), .outQ(outQ), .outValid(outValid), .outReal(outReal));
`default_nettype wire

// [ddc_host_model.sv]
// Purpose: host sink for the decimated stream
// Assumes: no back-pressure on the stream
// Notes:   keeps every word for the bench
`timescale 1ns/1ps
`default_nettype none
module ddc_host_model (
	// clock and reset
	input wire logic                             clk_sys,
	input wire logic                             rst,
	// decimated stream
	input wire logic signed [ddc_pkg::ACC_W-1:0] outI,
	input wire logic signed [ddc_pkg::ACC_W-1:0] outQ,
	input wire logic                             outValid,
	input wire logic                             outReal
);
	logic signed [ddc_pkg::ACC_W-1:0] rxI[$];
	logic signed [ddc_pkg::ACC_W-1:0] rxQ[$];
	logic                             rxReal[$];
	always @(posedge clk_sys) begin
		if (!rst && outValid === 1'b1) begin
			rxI.push_back(outI);
			rxQ.push_back(outQ);
			rxReal.push_back(outReal);
		end
	end
endmodule : ddc_host_model
`default_nettype wire

// [test_ddc_nco_decimator.sv]
// Purpose: self-checking bench of the down-conversion block
// Assumes: register reads answer one cycle later
// Notes:   each setc control write toggles the soft align bit; the restart write toggles only the restart bit
`timescale 1ns/1ps
`default_nettype none
module test_ddc_nco_decimator;
	logic               clk_sys = 1'b0;
	logic               rst = 1'b1;
	logic [7:0]         regAddr = 8'h0;
	logic [31:0]        regWrData = 32'h0;
	logic               regWr = 1'b0;
	logic               regRd = 1'b0;
	logic [31:0]        regRdData;
	logic signed [13:0] smpIn = 14'h0;
	logic               smpValid = 1'b0;
	logic               pin = 1'b0;
	logic               powerDown, outValid, outReal;
	logic signed [19:0] outI, outQ;
	logic [7:0]         ctrl = 8'h0;
	logic [31:0]        w;
	logic signed [13:0] x;
	int                 fails = 0, checked = 0, seed = 58, cyc = 0, base, k, j;
	ddc_nco_decimator dut (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
		.regWr(regWr), .regRd(regRd), .regRdData(regRdData), .smpIn(smpIn), .smpValid(smpValid),
		.powerdown_or_align_pin(pin), .powerDown(powerDown), .outI(outI), .outQ(outQ),
		.outValid(outValid), .outReal(outReal));
	ddc_host_model host (.clk_sys(clk_sys), .rst(rst), .outI(outI), .outQ(outQ), .outValid(outValid),
		.outReal(outReal));
	always #4 clk_sys = ~clk_sys;
	always @(posedge clk_sys) cyc <= cyc + 1;
	function automatic int expReal(input int v, input bit g);
		return g ? v * 90 : v * 64;
	endfunction : expReal
	// zero word: cosine at table peak 2047, scaled by 2^-5, doubled by complex gain
	function automatic int expCplx(input int v);
		return 2 * ((v * 2047) >>> 5);
	endfunction : expCplx
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic test_done;
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : test_done
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		regAddr <= a;
		regWrData <= v;
		regWr <= 1'b1;
		@(posedge clk_sys);
		regWr <= 1'b0;
		@(posedge clk_sys);
	endtask : wr
	task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
		logic [31:0] d;
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk_sys);
		regRd <= 1'b0;
		#1 d = regRdData;
		chk(nm, d, e);
		@(posedge clk_sys);
	endtask : rc
	// write control and toggle soft align, so counters and phase restart
	task automatic setc(input logic [7:0] v);
		ctrl = (v & 8'h3F) | (ctrl & 8'h40) | (~ctrl & 8'h80);
		wr(ddc_pkg::OFS_CTRL, 32'(ctrl));
	endtask : setc
	task automatic feed(input int n);
		int sent;
		logic v;
		sent = 0;
		while (sent < n) begin
			v = ($random(seed) & 3) != 0;
			smpIn <= x;
			smpValid <= v;
			sent += int'(v);
			@(posedge clk_sys);
		end
		smpValid <= 1'b0;
		repeat (8) @(posedge clk_sys);
	endtask : feed
	initial begin
		repeat (20000) @(posedge clk_sys);
		fails++;
		test_done();
	end
	initial begin
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		for (k = 0; k < 6; k++) rc(8'(k * 4), 32'h0, "reset value");
		w = $random(seed);
		wr(ddc_pkg::OFS_FREQ, w);
		rc(ddc_pkg::OFS_ACTIVE, 32'h0, "active before restart");
		rc(ddc_pkg::OFS_FREQ, w, "pending word");
		ctrl = ctrl ^ 8'h40;
		wr(ddc_pkg::OFS_CTRL, 32'(ctrl));
		rc(ddc_pkg::OFS_ACTIVE, w, "active after restart");
		for (k = 0; k < 8; k++) begin
			wr(ddc_pkg::OFS_DECIM, 32'(k));
			rc(ddc_pkg::OFS_DECIM, (k > 4) ? 32'h4 : 32'(k), "decimation code");
		end
		// second sample of an eighth-turn word: sign of Q shows rotation
		x = 14'(1 + ($random(seed) & 32'hFFF));
		for (k = 0; k < 4; k++) begin
			wr(ddc_pkg::OFS_FREQ, k[0] ? 32'hE000_0000 : 32'h2000_0000);
			setc(8'h02 | (k[1] ? 8'h10 : 8'h00));
			base = host.rxQ.size();
			feed(2);
			chk("q sign", 32'(host.rxQ[base + 1] > 0), 32'(k[0] == k[1]));
			chk("complex flag", 32'(host.rxReal[base + 1]), 32'h0);
		end
		for (k = 0; k < 5; k++) begin
			x = 14'(1 + ($random(seed) & 32'hFFF));
			wr(ddc_pkg::OFS_DECIM, 32'(k));
			setc(8'h01 | (k[0] ? 8'h04 : 8'h00));
			base = host.rxI.size();
			feed(64);
			j = host.rxI.size() - 1;
			chk("output count", 32'(j + 1 - base), 32'(64 >> (k + 1)));
			chk("real value", 32'(host.rxI[j]), 32'(expReal(int'(x), k[0])));
			chk("real flag", 32'(host.rxReal[j]), 32'h1);
		end
		wr(ddc_pkg::OFS_DECIM, 32'h0);
		wr(ddc_pkg::OFS_FREQ, 32'h0);
		setc(8'h0B);
		base = host.rxI.size();
		feed(16);
		chk("remix count", 32'(host.rxI.size() - base), 32'd16);
		chk("remix second", 32'(host.rxI[base + 1]), 32'h0);
		chk("remix third", 32'(host.rxI[base + 2]), 32'(-host.rxI[base]));
		chk("remix flag", 32'(host.rxReal[base]), 32'h1);
		setc(8'h07);
		base = host.rxI.size();
		feed(4);
		chk("complex count", 32'(host.rxI.size() - base), 32'h2);
		chk("complex gain", 32'(host.rxI[base + 1]), 32'(expCplx(int'(x))));
		chk("complex q", 32'(host.rxQ[base + 1]), 32'h0);
		chk("complex stream flag", 32'(host.rxReal[base + 1]), 32'h0);
		setc(8'h00);
		pin <= 1'b1;
		repeat (5) @(posedge clk_sys);
		chk("powerdown", 32'(powerDown), 32'h1);
		pin <= 1'b0;
		setc(8'h21);
		w = $random(seed);
		wr(ddc_pkg::OFS_FREQ, w);
		rc(ddc_pkg::OFS_ACTIVE, 32'h0, "active before pin");
		for (k = 0; k < 64 && cyc % 64 != 0; k++) @(posedge clk_sys);
		pin <= 1'b1;
		repeat (6) @(posedge clk_sys);
		chk("powerdown in align", 32'(powerDown), 32'h0);
		pin <= 1'b0;
		rc(ddc_pkg::OFS_ACTIVE, w, "active after pin");
		test_done();
	end
endmodule : test_ddc_nco_decimator
`default_nettype wire
